// file: hdl/image_map_pkg.sv
// Constants for the process image mapper
`default_nettype none
package image_map_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned AI_WORDS = 10;
  // Input image, analog area (byte offsets)
  localparam logic [4:0] AI1_BASE = 5'h00;
  localparam logic [4:0] AI2_BASE = 5'h04;
  localparam logic [4:0] AI4_BASE = 5'h08;
  localparam logic [4:0] HART_BASE = 5'h10;
  localparam int unsigned HART_CH1_WORD = 8;
  localparam int unsigned HART_CH2_WORD = 9;
  // Mailbox layout relative to the HART area
  localparam logic [4:0] MBX_STATUS_REL = 5'h00;
  localparam logic [4:0] MBX_INTERNAL_REL = 5'h01;
  localparam logic [4:0] MBX_DATA_REL = 5'h02;
  localparam logic [4:0] MBX_VALUES_REL = 5'h08;
  localparam logic [4:0] MBX_LEN = 5'h0C;
  localparam logic [4:0] HART_PLAIN_LEN = 5'h04;
  // Digital area start in the input image, per mode
  localparam logic [4:0] IN_DIG_PLAIN = 5'h14;
  localparam logic [4:0] IN_DIG_MBX = 5'h1C;
  // Output image: digital area start per mode
  localparam logic [4:0] OUT_DIG_PLAIN = 5'h00;
  localparam logic [4:0] OUT_DIG_MBX = 5'h0C;
  localparam logic [4:0] DO16_LO_REL = 5'h00;
  localparam logic [4:0] DO16_HI_REL = 5'h01;
  localparam logic [4:0] DIO_OUT_REL = 5'h02;
  localparam logic [4:0] DODIAG_OUT_REL = 5'h03;
  localparam logic [4:0] DIO_IN_REL = 5'h00;
  localparam logic [4:0] DO_FAULT_REL = 5'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [47:0] MBX_ZERO = 48'h000000000000;
endpackage : image_map_pkg
`default_nettype wire

// file: hdl/analog_word_capture.sv
// One analog channel: measured word and its private control/status bits
`default_nettype none
module analog_word_capture (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [15:0] value_in,
  input wire logic [7:0] cs_in,
  output logic [15:0] word_out,
  output logic [7:0] cs_out
);
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      word_out <= image_map_pkg::WORD_ZERO;
    end else begin
      word_out <= value_in;
    end
  end

  // Control/status bits stay on the internal configuration path
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      cs_out <= image_map_pkg::BYTE_ZERO;
    end else begin
      cs_out <= cs_in;
    end
  end
endmodule : analog_word_capture
`default_nettype wire

// file: hdl/io_process_image_mapper.sv
// Packs module data into the controller's input and output process images
`default_nettype none
module io_process_image_mapper (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic hart_mailbox_mode_in,
  input wire logic in_rd_in,
  input wire logic [4:0] in_addr_in,
  output logic [7:0] in_rdata_out,
  input wire logic out_wr_in,
  input wire logic [4:0] out_addr_in,
  input wire logic [7:0] out_wdata_in,
  input wire logic [159:0] ai_value_in,
  input wire logic [79:0] ai_cs_in,
  output logic [79:0] ai_cs_out,
  input wire logic [7:0] digital_input_channel_in,
  input wire logic [7:0] do_fault_in,
  input wire logic [7:0] mailbox_status_byte_in,
  input wire logic [7:0] hart_internal_byte_in,
  input wire logic [47:0] mailbox_response_bytes_in,
  output logic [7:0] mailbox_control_byte_out,
  output logic [47:0] mailbox_request_bytes_out,
  output logic mailbox_request_strobe_out,
  output logic [15:0] do16_out,
  output logic [7:0] dio_out,
  output logic [7:0] dodiag_out
);
  // ************************************************************
  // Analog channel capture
  // ************************************************************
  logic [15:0] ai_word [image_map_pkg::AI_WORDS];

  // Word order: 1ch sig/ref, 2ch ch1/ch2, 4ch ch1-4, HART ch1/ch2
  for (genvar k = 0; k < image_map_pkg::AI_WORDS; k++) begin : g_ai
    analog_word_capture u_cap (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .value_in(ai_value_in[16*k +: 16]),
      .cs_in(ai_cs_in[8*k +: 8]),
      .word_out(ai_word[k]),
      .cs_out(ai_cs_out[8*k +: 8])
    );
  end

  // ************************************************************
  // Mode dependent layout
  // ************************************************************
  logic [4:0] in_dig_base;
  logic [4:0] out_dig_base;
  logic [4:0] hart_len;

  always_comb begin
    if (hart_mailbox_mode_in) begin
      in_dig_base = image_map_pkg::IN_DIG_MBX;
      out_dig_base = image_map_pkg::OUT_DIG_MBX;
      hart_len = image_map_pkg::MBX_LEN;
    end else begin
      in_dig_base = image_map_pkg::IN_DIG_PLAIN;
      out_dig_base = image_map_pkg::OUT_DIG_PLAIN;
      hart_len = image_map_pkg::HART_PLAIN_LEN;
    end
  end

  // ************************************************************
  // Input image read
  // ************************************************************
  logic [7:0] rd_byte;
  logic [4:0] hart_rel;
  logic [4:0] dig_rel;
  logic [3:0] word_sel;

  always_comb begin
    rd_byte = image_map_pkg::BYTE_ZERO;
    hart_rel = in_addr_in - image_map_pkg::HART_BASE;
    dig_rel = in_addr_in - in_dig_base;
    word_sel = in_addr_in[4:1];
    if (in_addr_in < image_map_pkg::HART_BASE) begin
      rd_byte = in_addr_in[0] ? ai_word[word_sel][15:8] :
                                ai_word[word_sel][7:0];
    end else if (in_addr_in < in_dig_base) begin
      if (!hart_mailbox_mode_in) begin
        word_sel = 4'(image_map_pkg::HART_CH1_WORD) + {3'h0, hart_rel[1]};
        rd_byte = hart_rel[0] ? ai_word[word_sel][15:8] :
                                ai_word[word_sel][7:0];
      end else if (hart_rel == image_map_pkg::MBX_STATUS_REL) begin
        rd_byte = mailbox_status_byte_in;
      end else if (hart_rel == image_map_pkg::MBX_INTERNAL_REL) begin
        rd_byte = hart_internal_byte_in;
      end else if (hart_rel < image_map_pkg::MBX_VALUES_REL) begin
        rd_byte = mailbox_response_bytes_in[
          8*(32'(hart_rel) - 32'(image_map_pkg::MBX_DATA_REL)) +: 8];
      end else begin
        word_sel = 4'(image_map_pkg::HART_CH1_WORD) + {3'h0, hart_rel[1]};
        rd_byte = hart_rel[0] ? ai_word[word_sel][15:8] :
                                ai_word[word_sel][7:0];
      end
    end else if (dig_rel == image_map_pkg::DIO_IN_REL) begin
      rd_byte = digital_input_channel_in;
    end else if (dig_rel == image_map_pkg::DO_FAULT_REL) begin
      rd_byte = do_fault_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      in_rdata_out <= image_map_pkg::BYTE_ZERO;
    end else if (in_rd_in) begin
      in_rdata_out <= rd_byte;
    end
  end

  // ************************************************************
  // Output image write
  // ************************************************************
  logic [4:0] wr_dig_rel;
  logic [4:0] wr_hart_rel;
  logic wr_dig;
  logic wr_mbx;

  assign wr_dig_rel = out_addr_in - out_dig_base;
  assign wr_hart_rel = out_addr_in;
  assign wr_dig = out_wr_in && (out_addr_in >= out_dig_base);
  assign wr_mbx = out_wr_in && hart_mailbox_mode_in &&
                  (out_addr_in < hart_len);

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      do16_out <= image_map_pkg::WORD_ZERO;
    end else if (wr_dig && wr_dig_rel == image_map_pkg::DO16_LO_REL) begin
      do16_out[7:0] <= out_wdata_in;
    end else if (wr_dig && wr_dig_rel == image_map_pkg::DO16_HI_REL) begin
      do16_out[15:8] <= out_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      dio_out <= image_map_pkg::BYTE_ZERO;
    end else if (wr_dig && wr_dig_rel == image_map_pkg::DIO_OUT_REL) begin
      dio_out <= out_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      dodiag_out <= image_map_pkg::BYTE_ZERO;
    end else if (wr_dig && wr_dig_rel == image_map_pkg::DODIAG_OUT_REL) begin
      dodiag_out <= out_wdata_in;
    end
  end

  // Mailbox: byte 0 control, bytes 2-7 request, rest dropped
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      mailbox_control_byte_out <= image_map_pkg::BYTE_ZERO;
      mailbox_request_bytes_out <= image_map_pkg::MBX_ZERO;
    end else if (wr_mbx) begin
      if (wr_hart_rel == image_map_pkg::MBX_STATUS_REL) begin
        mailbox_control_byte_out <= out_wdata_in;
      end else if (wr_hart_rel >= image_map_pkg::MBX_DATA_REL &&
                   wr_hart_rel < image_map_pkg::MBX_VALUES_REL) begin
        mailbox_request_bytes_out[
          8*(32'(wr_hart_rel) - 32'(image_map_pkg::MBX_DATA_REL)) +: 8]
          <= out_wdata_in;
      end
    end
  end

  // Pulse when the control byte is written, hands the request over
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      mailbox_request_strobe_out <= 1'b0;
    end else begin
      mailbox_request_strobe_out <= wr_mbx &&
        (wr_hart_rel == image_map_pkg::MBX_STATUS_REL);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_do16_low_byte: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (wr_dig && wr_dig_rel == image_map_pkg::DO16_LO_REL) |=>
      do16_out[7:0] == $past(out_wdata_in) && $stable(do16_out[15:8]))
    else $error("low output byte not on channels 1-8");
  chk_do16_high_byte: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (wr_dig && wr_dig_rel == image_map_pkg::DO16_HI_REL) |=>
      do16_out[15:8] == $past(out_wdata_in))
    else $error("high output byte not on channels 9-16");
  chk_dio_input_read: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (in_rd_in && in_addr_in == in_dig_base) |=>
      in_rdata_out == $past(digital_input_channel_in))
    else $error("combined input byte misplaced");
  chk_ai_low_first: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (in_rd_in && in_addr_in == image_map_pkg::AI4_BASE + 5'h01) |=>
      in_rdata_out == $past(ai_word[4][15:8]))
    else $error("analog word byte order wrong");
  chk_ai_first_word: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (in_rd_in && in_addr_in == image_map_pkg::AI1_BASE) |=>
      in_rdata_out == $past(ai_value_in[7:0], 2))
    else $error("signal value not at word 0");
  chk_hart_plain_word: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (in_rd_in && !hart_mailbox_mode_in &&
     in_addr_in == image_map_pkg::HART_BASE) |=>
      in_rdata_out == $past(ai_word[8][7:0]))
    else $error("plain HART channel 1 misplaced");
  chk_mbx_status_read: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (in_rd_in && hart_mailbox_mode_in &&
     in_addr_in == image_map_pkg::HART_BASE) |=>
      in_rdata_out == $past(mailbox_status_byte_in))
    else $error("mailbox status byte misplaced");
  chk_mbx_value_read: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (in_rd_in && hart_mailbox_mode_in && in_addr_in == 5'h1A) |=>
      in_rdata_out == $past(ai_word[9][7:0]))
    else $error("mailbox channel 2 value misplaced");
  chk_mbx_ctrl_write: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (out_wr_in && hart_mailbox_mode_in && out_addr_in == 5'h00) |=>
      mailbox_control_byte_out == $past(out_wdata_in) &&
      mailbox_request_strobe_out)
    else $error("mailbox control byte not taken");
  chk_unused_reads_zero: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    (in_rd_in && in_addr_in > in_dig_base + 5'h01) |=>
      in_rdata_out == image_map_pkg::BYTE_ZERO)
    else $error("unused input byte not zero");
endmodule : io_process_image_mapper
`default_nettype wire

// file: verification/image_host_model.sv
// Controller model that reads and writes the process images
`default_nettype none
module image_host_model (
  input wire logic ref_clk_in,
  output logic rd_out,
  output logic [4:0] rd_addr_out,
  input wire logic [7:0] rdata_in,
  output logic wr_out,
  output logic [4:0] wr_addr_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************
  // Image accesses
  // ***********************
  initial begin
    rd_out = 1'b0;
    rd_addr_out = 5'h00;
    wr_out = 1'b0;
    wr_addr_out = 5'h00;
    wdata_out = 8'h00;
  end
  task automatic read_byte(input logic [4:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    rd_out = 1'b1;
    rd_addr_out = a;
    @(negedge ref_clk_in);
    rd_out = 1'b0;
    rd_addr_out = ~a;
    d = rdata_in;
  endtask : read_byte
  // Mailbox request bytes are written by this side
  task automatic write_byte(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    wr_out = 1'b1;
    wr_addr_out = a;
    wdata_out = d;
    @(negedge ref_clk_in);
    wr_out = 1'b0;
    wr_addr_out = ~a;
    wdata_out = ~d;
  endtask : write_byte
endmodule : image_host_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the process image mapper
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic rd, wr, strobe;
  logic [4:0] ra, wa;
  logic [7:0] rdata, wdata, di, flt, st, ib, ctl, dio, dd, d;
  logic [159:0] ai_v = '0;
  logic [79:0] ai_cs = '0;
  logic [79:0] ai_cs_o;
  logic [47:0] resp, req;
  logic [15:0] do16;
  int n_errors = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  io_process_image_mapper dut (.ref_clk_in(clk), .reset_n_in(rst_n),
    .hart_mailbox_mode_in(mode), .in_rd_in(rd), .in_addr_in(ra),
    .in_rdata_out(rdata), .out_wr_in(wr), .out_addr_in(wa),
    .out_wdata_in(wdata), .ai_value_in(ai_v), .ai_cs_in(ai_cs),
    .ai_cs_out(ai_cs_o), .digital_input_channel_in(di), .do_fault_in(flt),
    .mailbox_status_byte_in(st), .hart_internal_byte_in(ib),
    .mailbox_response_bytes_in(resp), .mailbox_control_byte_out(ctl),
    .mailbox_request_bytes_out(req), .mailbox_request_strobe_out(strobe),
    .do16_out(do16), .dio_out(dio), .dodiag_out(dd));
  image_host_model host (.ref_clk_in(clk), .rd_out(rd), .rd_addr_out(ra),
    .rdata_in(rdata), .wr_out(wr), .wr_addr_out(wa), .wdata_out(wdata));
  // ***********************
  // Checks and scenarios
  // ***********************
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input int a, input logic [7:0] exp);
    host.read_byte(5'(a), d);
    chk(80'(d), 80'(exp));
  endtask : rd_chk
  task automatic t_reset;
    chk({do16, dio, dd, ctl, strobe, rdata}, 80'h0);
    chk({req, ai_cs_o[31:0]}, 80'h0);
  endtask : t_reset
  task automatic t_analog;
    @(negedge clk);
    for (int k = 0; k < 10; k++) begin
      ai_v[16*k+:16] = {8'(8'hC0 + k), 8'(8'h30 + k)};
      ai_cs[8*k+:8] = 8'(8'hE0 + k);
    end
    repeat (2) @(negedge clk);
    chk(ai_cs_o, ai_cs);
    for (int b = 0; b < 20; b++) begin
      rd_chk(b, b[0] ? 8'(8'hC0 + b / 2)
        : 8'(8'h30 + b / 2));
    end
    for (int b = 22; b < 32; b++) rd_chk(b, 8'h00);
  endtask : t_analog
  task automatic t_digital;
    rd_chk(20, 8'h5A);
    rd_chk(21, 8'h81);
  endtask : t_digital
  task automatic t_out_plain;
    host.write_byte(5'h00, 8'h3C);
    host.write_byte(5'h01, 8'hA5);
    host.write_byte(5'h02, 8'h96);
    host.write_byte(5'h03, 8'h0F);
    host.write_byte(5'h05, 8'hFF);
    host.write_byte(5'h0C, 8'hFF);
    chk(80'(do16), 80'hA53C);
    chk(80'(dio), 80'h96);
    chk(80'(dd), 80'h0F);
    chk({ctl, req, strobe}, 80'h0);
  endtask : t_out_plain
  task automatic t_mailbox;
    @(negedge clk);
    mode = 1'b1;
    rd_chk(16, 8'h11);
    rd_chk(17, 8'h22);
    for (int j = 0; j < 6; j++) rd_chk(18 + j, 8'(8'h40 + j));
    for (int b = 24; b < 28; b++) begin
      rd_chk(b, b[0] ? 8'(8'hC8 + (b - 24) / 2)
        : 8'(8'h38 + (b - 24) / 2));
    end
    rd_chk(28, 8'h5A);
    rd_chk(30, 8'h00);
    host.write_byte(5'h00, 8'h7E);
    chk({ctl, strobe}, {8'h7E, 1'b1});
    @(negedge clk);
    chk(80'(strobe), 80'h0);
    for (int j = 0; j < 6; j++) host.write_byte(5'(2 + j), 8'(8'hB0 + j));
    host.write_byte(5'h01, 8'hFF);
    host.write_byte(5'h08, 8'hFF);
    host.write_byte(5'h0C, 8'hC3);
    chk(80'(req), 80'hB5B4B3B2B1B0);
    chk({ctl, do16}, {8'h7E, 16'hA5C3});
    @(negedge clk);
    mode = 1'b0;
    rd_chk(20, 8'h5A);
  endtask : t_mailbox
  task automatic summarize;
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    di = 8'h5A;
    flt = 8'h81;
    st = 8'h11;
    ib = 8'h22;
    resp = 48'h454443424140;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_analog();
    t_digital();
    t_out_plain();
    t_mailbox();
    summarize();
  end
  initial begin
    #20000;
    n_errors++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
